//--- bench/cfg_host_model.sv
/*
 * Host bridge model issuing configuration requests one at a time.
 * Assumes requests change on falling edges of ref_clk.
 */
`timescale 1ns/1ps

module cfg_host_model
(
   input  wire logic        ref_clk,
   input  wire logic        cfg_ack,
   input  wire logic        cfg_hit,
   input  wire logic [31:0] cfg_rdata,
   output      logic        cfg_req,
   output      logic        cfg_write,
   output      logic [2:0]  cfg_function,
   output      logic [7:0]  cfg_addr,
   output      logic [3:0]  cfg_byte_en,
   output      logic [31:0] cfg_wdata
);
   initial
   begin
      cfg_req = 1'b0;
      cfg_write = 1'b0;
      cfg_function = 3'h0;
      cfg_addr = 8'h00;
      cfg_byte_en = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end

   // ************************************************
   // One request, bounded wait for the answer
   // ************************************************
   task automatic access(input logic wr, input logic [2:0] fn, input logic [7:0] a,
                         input logic [3:0] be, input logic [31:0] wd,
                         output logic [31:0] rd, output logic hit, output bit ok,
                         output int lat);
      @(negedge ref_clk);
      cfg_req = 1'b1;
      cfg_write = wr;
      cfg_function = fn;
      cfg_addr = a;
      cfg_byte_en = be;
      cfg_wdata = wd;
      @(negedge ref_clk);
      // Released address and write data lines carry junk so stale values cannot pass
      cfg_req = 1'b0;
      cfg_addr = ~a;
      cfg_wdata = ~wd;
      for (lat = 0; lat < 4; lat++)
      begin
         if (cfg_ack === 1'b1)
            break;
         @(negedge ref_clk);
      end
      ok = (cfg_ack === 1'b1);
      rd = cfg_rdata;
      hit = cfg_hit;
   endtask
endmodule

//--- bench/test_pci_config_header_command.sv
/*
 * Self-checking bench of the configuration header front.
 * Assumes cfg_host_model and the design sources are compiled with it.
 */
`timescale 1ns/1ps
`include "pci_cfg_consts.svh"
`define check_eq(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end

module test_pci_config_header_command;
   logic        ref_clk, sys_rst, mem_cycle_hit, master_start_req;
   logic        master_write_req, addr_parity_err, data_parity_err;
   wire         cfg_req, cfg_write, cfg_ack, cfg_hit, mem_cycle_claim, master_start_ok;
   wire [2:0]   cfg_function;
   wire [7:0]   cfg_addr;
   wire [3:0]   cfg_byte_en, master_cmd;
   wire [31:0]  cfg_wdata, cfg_rdata;
   wire         system_error_output_o, system_error_output_oe;
   wire         parity_error_output_o, parity_error_output_oe;
   wire [15:0]  command_value;
   int          fails, n_checks, i;
   int          seed = 82;
   logic [15:0] cmd_m;
   logic [3:0]  mcmd_m, be;
   logic [31:0] rd, wd;
   logic [7:0]  adr;
   logic [2:0]  fn;
   logic        hit;

   pci_config_header_command i_pci_config_header_command
   (
      .ref_clk, .sys_rst, .cfg_req, .cfg_write, .cfg_function, .cfg_addr, .cfg_byte_en,
      .cfg_wdata, .cfg_ack, .cfg_hit, .cfg_rdata, .mem_cycle_hit, .mem_cycle_claim,
      .master_start_req, .master_start_ok, .master_write_req, .master_cmd,
      .addr_parity_err, .data_parity_err, .system_error_output_o,
      .system_error_output_oe, .parity_error_output_o, .parity_error_output_oe,
      .command_value
   );

   cfg_host_model i_cfg_host_model
   (
      .ref_clk, .cfg_ack, .cfg_hit, .cfg_rdata, .cfg_req, .cfg_write, .cfg_function,
      .cfg_addr, .cfg_byte_en, .cfg_wdata
   );

   always #50 ref_clk = ~ref_clk;

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic finish_test;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic do_cfg(input logic wr, input logic [2:0] f, input logic [7:0] a,
                         input logic [3:0] b, input logic [31:0] w);
      bit ok;
      int lat;
      i_cfg_host_model.access(wr, f, a, b, w, rd, hit, ok, lat);
      `check_eq("ack", 1'b1, ok)
      `check_eq("lat", 0, lat)
      if (!ok)
         finish_test();
   endtask

   // Random side inputs, gates and one-cycle responses against the model
   task automatic side_check;
      logic [4:0] r;
      r = 5'($random(seed));
      @(negedge ref_clk);
      {mem_cycle_hit, master_start_req, master_write_req} = r[2:0];
      {addr_parity_err, data_parity_err} = r[4:3];
      if (r[0])
         mcmd_m = cmd_m[4] ? 4'hf : 4'h7;
      #1;
      `check_eq("claim", r[2] & cmd_m[1], mem_cycle_claim)
      `check_eq("start", r[1] & cmd_m[2], master_start_ok)
      @(negedge ref_clk);
      {mem_cycle_hit, master_start_req, master_write_req} = 3'h0;
      {addr_parity_err, data_parity_err} = 2'h0;
      `check_eq("mcmd", mcmd_m, master_cmd)
      `check_eq("serr", r[4] & cmd_m[8], system_error_output_oe)
      `check_eq("perr", r[3] & cmd_m[6], parity_error_output_oe)
      `check_eq("pins", 2'h0, {system_error_output_o, parity_error_output_o})
      `check_eq("cmd", cmd_m, command_value)
   endtask

   // ************************************************
   // Main sequence
   // ************************************************
   initial
   begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      {mem_cycle_hit, master_start_req, master_write_req} = 3'h0;
      {addr_parity_err, data_parity_err} = 2'h0;
      cmd_m = 16'h0000;
      mcmd_m = 4'h7;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      sys_rst = 1'b0;
      `check_eq("rst", 16'h0000, command_value)
      `check_eq("rmcmd", 4'h7, master_cmd)
      do_cfg(1'b0, 3'h0, 8'h00, 4'h0, 32'h0);
      `check_eq("id", {`CFG_PART_IDENTIFIER_VALUE, `CFG_MAKER_IDENTIFIER_VALUE}, rd)
      // Memory response is enabled before the random register accesses
      do_cfg(1'b1, 3'h0, 8'h04, 4'h1, 32'h2);
      cmd_m = 16'h0002;
      side_check();
      for (i = 0; i < 30; i++)
      begin
         wd = $random(seed);
         be = 4'($random(seed));
         fn = (i % 5 == 4) ? (wd[2:0] | 3'h1) : 3'h0;
         adr = 8'(4 * (i % 3)) | {6'h0, wd[9:8]};
         do_cfg(1'b1, fn, adr, be, wd);
         `check_eq("whit", fn == 3'h0, hit)
         if (fn == 3'h0 && adr[7:2] == 6'h01)
         begin
            if (be[0])
               cmd_m[7:0] = wd[7:0] & 8'h56;
            if (be[1])
               cmd_m[15:8] = wd[15:8] & 8'h01;
         end
         do_cfg(1'b0, 3'h0, 8'h04, be, 32'h0);
         `check_eq("cmdrd", {16'h0, cmd_m}, rd)
         side_check();
      end
      do_cfg(1'b0, 3'h0, 8'h00, 4'hf, 32'h0);
      `check_eq("idw", {`CFG_PART_IDENTIFIER_VALUE, `CFG_MAKER_IDENTIFIER_VALUE}, rd)
      do_cfg(1'b0, 3'h2, 8'h08, 4'hf, 32'h0);
      `check_eq("fnhit", 1'b0, hit)
      `check_eq("fnrd", {`CFG_PART_IDENTIFIER_VALUE, `CFG_MAKER_IDENTIFIER_VALUE}, rd)
      do_cfg(1'b0, 3'h0, 8'h08, 4'hf, 32'h0);
      `check_eq("unmap", 32'h0, rd)
      @(negedge ref_clk);
      sys_rst = 1'b1;
      @(negedge ref_clk);
      sys_rst = 1'b0;
      cmd_m = 16'h0000;
      mcmd_m = 4'h7;
      `check_eq("rst2", 16'h0000, command_value)
      side_check();
      finish_test();
   end
endmodule

//--- src/cmd_bit_cell.sv
/*
 * One bit of the command register: writable storage or a hardwired zero.
 * Assumes the write strobe is a one-cycle pulse on ref_clk.
 */
`timescale 1ns/1ps

module cmd_bit_cell
   import pci_cfg_pkg::*;
#(
   parameter bit WRITABLE = 1'b0
)
(
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic wr_strobe,
   input  wire logic wr_value,
   output      logic bit_value
);

   cmd_bit_state_t state_reg;
   cmd_bit_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      // Unwritable bits ignore the write and stay zero
      if (WRITABLE && wr_strobe)
      begin
         state_next.value = wr_value;
      end
      if (!WRITABLE)
      begin
         state_next.value = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign bit_value = state_reg.value;

endmodule

//--- src/pci_cfg_consts.svh
/*
 * Constants of the configuration header front: offsets, field positions,
 * reset values and identification words.
 * Assumes it is included by bare name from the bench and the header module.
 */
`ifndef PCI_CFG_CONSTS_SVH
`define PCI_CFG_CONSTS_SVH

// ************************************************
// Register offsets (byte addresses)
// ************************************************
`define CFG_OFS_MAKER_IDENTIFIER        8'h00
`define CFG_OFS_PART_IDENTIFIER         8'h02
`define CFG_OFS_BUS_INTERFACE_CONTROL   8'h04

// ************************************************
// Identification words (arbitrary values)
// ************************************************
`define CFG_MAKER_IDENTIFIER_VALUE      16'h5a31
`define CFG_PART_IDENTIFIER_VALUE       16'h0c17

// ************************************************
// Command field positions
// ************************************************
`define CMD_IO_SPACE_ENABLE_BIT         0
`define CMD_MEMORY_RESPONSE_ENABLE_BIT  1
`define CMD_BUS_MASTER_ENABLE_BIT       2
`define CMD_SPECIAL_CYCLE_BIT           3
`define CMD_WRITE_INVALIDATE_ENABLE_BIT 4
`define CMD_PALETTE_SNOOP_ENABLE_BIT    5
`define CMD_PARITY_RESPONSE_ENABLE_BIT  6
`define CMD_STEPPING_CONTROL_BIT        7
`define CMD_SYSTEM_ERROR_ENABLE_BIT     8
`define CMD_FAST_B2B_ENABLE_BIT         9

// ************************************************
// Reset values and access masks
// ************************************************
`define CMD_RESET_VALUE                 16'h0000
`define CMD_WRITABLE_MASK               16'h0156
`define CFG_UNUSED_READ_VALUE           32'h0000_0000

`endif

//--- src/pci_cfg_pkg.sv
/*
 * Types shared by the configuration header front.
 * Assumes pci_cfg_consts.svh is on the include path.
 */
package pci_cfg_pkg;

   // ************************************************
   // Master write command codes
   // ************************************************
   typedef enum logic [3:0]
   {
      MEM_WRITE_CMD            = 4'b0111,
      MEM_WRITE_INVALIDATE_CMD = 4'b1111
   } write_cmd_t;

   // ************************************************
   // Module state
   // ************************************************
   typedef struct packed
   {
      logic        value;
   } cmd_bit_state_t;

   typedef struct packed
   {
      logic        cfg_ack;
      logic        cfg_hit;
      logic [31:0] cfg_rdata;
      write_cmd_t  master_cmd;
      logic        system_error_oe;
      logic        parity_error_oe;
   } cfg_state_t;

endpackage

//--- src/pci_config_header_command.sv
/*
 * Configuration header front: identification words and command register,
 * plus the gating that the command bits apply to the rest of the device.
 * Assumes a PCI target front end on ref_clk that decodes configuration
 * cycles into single-cycle requests, and device logic on the same clock.
 */
// Overview of operation
// - One function only, standard header layout
// - Maker identifier at 00h, read-only
// - Part identifier at 02h, writes ignored
// - Command bits 15-10 read zero
// - Fast back-to-back enable reads zero
// - Bit 8 enables system error driver
// - Stepping control bit hardwired zero
// - Bit 6 enables parity error response
// - Palette snoop enable reads zero
// - Bit 4 allows write-and-invalidate commands
// - Bit 4 clear: plain memory writes
// - Special cycle bit zero, cycles ignored
// - Bit 2 gates bus mastering
// - Bit 1 gates memory cycle claims
// - I/O space enable reads zero
// - Writable fields store, read-only ignore writes
`timescale 1ns/1ps
`include "pci_cfg_consts.svh"

module pci_config_header_command
   import pci_cfg_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        cfg_req,
   input  wire logic        cfg_write,
   input  wire logic [2:0]  cfg_function,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic [31:0] cfg_wdata,
   output      logic        cfg_ack,
   output      logic        cfg_hit,
   output      logic [31:0] cfg_rdata,
   input  wire logic        mem_cycle_hit,
   output      logic        mem_cycle_claim,
   input  wire logic        master_start_req,
   output      logic        master_start_ok,
   input  wire logic        master_write_req,
   output      logic [3:0]  master_cmd,
   input  wire logic        addr_parity_err,
   input  wire logic        data_parity_err,
   output      logic        system_error_output_o,
   output      logic        system_error_output_oe,
   output      logic        parity_error_output_o,
   output      logic        parity_error_output_oe,
   output      logic [15:0] command_value
);

   // ************************************************
   // Request decode
   // ************************************************
   logic        func_ok;
   logic        is_word0;
   logic        is_word1;
   logic [15:0] cmd_wr_strobe;
   logic [31:0] read_word;
   cfg_state_t  state_reg;
   cfg_state_t  state_next;

   assign func_ok  = (cfg_function == 3'h0);
   assign is_word0 = (cfg_addr[7:2] == 6'(`CFG_OFS_MAKER_IDENTIFIER >> 2));
   assign is_word1 = (cfg_addr[7:2] == 6'(`CFG_OFS_BUS_INTERFACE_CONTROL >> 2));

   // ************************************************
   // Command register bits
   // ************************************************
   // Word 0 has no write path at all, so the identifiers cannot change
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         cmd_wr_strobe[i] = cfg_req && cfg_write && func_ok && is_word1
                            && cfg_byte_en[i / 8];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : g_cmd
         cmd_bit_cell #(
            .WRITABLE (1'(`CMD_WRITABLE_MASK >> g))
         ) u_cell (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .wr_strobe (cmd_wr_strobe[g]),
            .wr_value  (cfg_wdata[g]),
            .bit_value (command_value[g])
         );
      end
   endgenerate

   // ************************************************
   // Read data
   // ************************************************
   // Status half of word 1 lies outside this block and reads zero here
   always_comb
   begin
      if (is_word0)
      begin
         read_word = {`CFG_PART_IDENTIFIER_VALUE,
                      `CFG_MAKER_IDENTIFIER_VALUE};
      end
      else if (is_word1)
      begin
         read_word = {16'h0000, command_value};
      end
      else
      begin
         read_word = `CFG_UNUSED_READ_VALUE;
      end
   end

   // ************************************************
   // State update
   // ************************************************
   always_comb
   begin
      state_next         = state_reg;
      state_next.cfg_ack = cfg_req;
      state_next.cfg_hit = cfg_req && func_ok;
      if (cfg_req && func_ok && !cfg_write)
      begin
         state_next.cfg_rdata = read_word;
      end
      // Command chosen per master write request; bit 4 sampled at that moment
      if (master_write_req)
      begin
         if (command_value[`CMD_WRITE_INVALIDATE_ENABLE_BIT])
         begin
            state_next.master_cmd = MEM_WRITE_INVALIDATE_CMD;
         end
         else
         begin
            state_next.master_cmd = MEM_WRITE_CMD;
         end
      end
      state_next.system_error_oe = addr_parity_err
                                   && command_value[`CMD_SYSTEM_ERROR_ENABLE_BIT];
      state_next.parity_error_oe = data_parity_err
                                   && command_value[`CMD_PARITY_RESPONSE_ENABLE_BIT];
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_reg            <= '0;
         state_reg.master_cmd <= MEM_WRITE_CMD;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign cfg_ack   = state_reg.cfg_ack;
   assign cfg_hit   = state_reg.cfg_hit;
   assign cfg_rdata = state_reg.cfg_rdata;
   assign master_cmd = state_reg.master_cmd;
   // Host must enable memory space first; until then claims are refused
   assign mem_cycle_claim = mem_cycle_hit
                            && command_value[`CMD_MEMORY_RESPONSE_ENABLE_BIT];
   assign master_start_ok = master_start_req
                            && command_value[`CMD_BUS_MASTER_ENABLE_BIT];
   // Open-drain pins: only ever pulled low
   assign system_error_output_o  = 1'b0;
   assign system_error_output_oe = state_reg.system_error_oe;
   assign parity_error_output_o  = 1'b0;
   assign parity_error_output_oe = state_reg.parity_error_oe;

   // ************************************************
   // Assertions
   // ************************************************
   property p_single_function;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && (cfg_function != 3'h0) |=> cfg_ack && !cfg_hit;
   endproperty
   a_single_function: assert property (p_single_function)
      else $error("non-zero function was claimed");

   property p_maker_id;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && !cfg_write && func_ok && is_word0
      |=> cfg_rdata[15:0] == `CFG_MAKER_IDENTIFIER_VALUE;
   endproperty
   a_maker_id: assert property (p_maker_id)
      else $error("maker identifier read wrong");

   property p_part_id;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && !cfg_write && func_ok && is_word0
      |=> cfg_rdata[31:16] == `CFG_PART_IDENTIFIER_VALUE;
   endproperty
   a_part_id: assert property (p_part_id)
      else $error("part identifier read wrong");

   property p_fixed_zero;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && cfg_write && func_ok && is_word1
      |=> ##1 (command_value & ~`CMD_WRITABLE_MASK) == 16'h0000;
   endproperty
   a_fixed_zero: assert property (p_fixed_zero)
      else $error("read-only command bit became set");

   property p_rw_store;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && cfg_write && func_ok && is_word1 && cfg_byte_en[0]
      |=> command_value[7:0] == ($past(cfg_wdata[7:0]) & `CMD_WRITABLE_MASK);
   endproperty
   a_rw_store: assert property (p_rw_store)
      else $error("writable command bits did not store");

   property p_serr;
      @(posedge ref_clk) disable iff (sys_rst)
      addr_parity_err |=> system_error_output_oe
                          == $past(command_value[`CMD_SYSTEM_ERROR_ENABLE_BIT]);
   endproperty
   a_serr: assert property (p_serr)
      else $error("system error drive does not follow enable");

   property p_perr;
      @(posedge ref_clk) disable iff (sys_rst)
      !data_parity_err |=> !parity_error_output_oe;
   endproperty
   a_perr: assert property (p_perr)
      else $error("parity error driven without cause");

   property p_perr_on;
      @(posedge ref_clk) disable iff (sys_rst)
      data_parity_err && command_value[`CMD_PARITY_RESPONSE_ENABLE_BIT]
      |=> parity_error_output_oe && !parity_error_output_o;
   endproperty
   a_perr_on: assert property (p_perr_on)
      else $error("enabled parity response missing");

   property p_write_cmd;
      @(posedge ref_clk) disable iff (sys_rst)
      master_write_req |=> master_cmd == ($past(command_value[4]) ?
                           4'hf : 4'h7);
   endproperty
   a_write_cmd: assert property (p_write_cmd)
      else $error("master write command wrong for enable");

   property p_master;
      @(posedge ref_clk) disable iff (sys_rst)
      master_start_ok |-> command_value[`CMD_BUS_MASTER_ENABLE_BIT];
   endproperty
   a_master: assert property (p_master)
      else $error("master start without enable");

   property p_memory;
      @(posedge ref_clk) disable iff (sys_rst)
      mem_cycle_hit |-> mem_cycle_claim
                        == command_value[`CMD_MEMORY_RESPONSE_ENABLE_BIT];
   endproperty
   a_memory: assert property (p_memory)
      else $error("memory claim does not follow enable");

   property p_reset;
      @(posedge ref_clk)
      sys_rst |=> command_value == `CMD_RESET_VALUE && !cfg_ack;
   endproperty
   a_reset: assert property (p_reset)
      else $error("command not cleared by reset");

   property p_ack_idle;
      @(posedge ref_clk) disable iff (sys_rst)
      !cfg_req |=> !cfg_ack && !cfg_hit;
   endproperty
   a_ack_idle: assert property (p_ack_idle)
      else $error("answer without a request");

   property p_hit_fn0;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && func_ok |=> cfg_ack && cfg_hit;
   endproperty
   a_hit_fn0: assert property (p_hit_fn0)
      else $error("function zero request not claimed");

   property p_rdata_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      !(cfg_req && func_ok && !cfg_write) |=> $stable(cfg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a claimed read");

   property p_id_write;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && cfg_write && is_word0 |=> $stable(command_value);
   endproperty
   a_id_write: assert property (p_id_write)
      else $error("write to identifier word changed the command");

   property p_rw_store_high;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && cfg_write && func_ok && is_word1 && cfg_byte_en[1]
      |=> command_value[15:8] == ($past(cfg_wdata[15:8]) & (`CMD_WRITABLE_MASK >> 8));
   endproperty
   a_rw_store_high: assert property (p_rw_store_high)
      else $error("writable upper command bit did not store");

   property p_lane_kept;
      @(posedge ref_clk) disable iff (sys_rst)
      cfg_req && cfg_write && !cfg_byte_en[0] |=> $stable(command_value[7:0]);
   endproperty
   a_lane_kept: assert property (p_lane_kept)
      else $error("disabled byte lane changed the command");

   property p_serr_off;
      @(posedge ref_clk) disable iff (sys_rst)
      !addr_parity_err |=> !system_error_output_oe && !system_error_output_o;
   endproperty
   a_serr_off: assert property (p_serr_off)
      else $error("system error driven without cause");

   property p_mcmd_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      !master_write_req |=> $stable(master_cmd);
   endproperty
   a_mcmd_hold: assert property (p_mcmd_hold)
      else $error("master command changed without a write request");

   property p_start_gate;
      @(posedge ref_clk) disable iff (sys_rst)
      master_start_req && command_value[`CMD_BUS_MASTER_ENABLE_BIT] |-> master_start_ok;
   endproperty
   a_start_gate: assert property (p_start_gate)
      else $error("enabled master start refused");

   c_cmd_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_req && cfg_write && is_word1 ##2 command_value[1]);
   c_id_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_req && !cfg_write && is_word0 ##1 cfg_hit);
   c_mwi: cover property (@(posedge ref_clk) disable iff (sys_rst)
      master_write_req ##1 master_cmd == 4'hf);
   c_serr: cover property (@(posedge ref_clk) disable iff (sys_rst)
      system_error_output_oe);

endmodule
